// [hdl/cbt_pkg.sv]
/*
 * Shared constants and types of the CAN bit timing, transmit priority and
 * DLC filter block. Assumes a single 10 MHz clock domain.
 */
package cbt_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] CBT_NOM_OFS = 8'h00;
    localparam logic [7:0] CBT_DAT_OFS = 8'h04;
    localparam logic [7:0] CBT_GCF_OFS = 8'h08;
    localparam logic [7:0] CBT_STS_OFS = 8'h0C;

    // nominal_bit_config_low fields (segment fields hold length - 1)
    localparam int CBT_NOM_BRP_POS = 0;
    localparam int CBT_NOM_TS1_POS = 10;
    localparam int CBT_NOM_TS2_POS = 18;
    localparam int CBT_NOM_SJW_POS = 25;
    // data_bit_config_low fields
    localparam int CBT_DAT_BRP_POS = 0;
    localparam int CBT_DAT_TS1_POS = 8;
    localparam int CBT_DAT_TS2_POS = 13;
    localparam int CBT_DAT_SJW_POS = 17;
    // global_config_low fields
    localparam int CBT_GCF_PRI_POS = 0;
    localparam int CBT_GCF_DCE_POS = 1;
    localparam int CBT_GCF_DRE_POS = 2;
    localparam int CBT_GCF_DPH_POS = 3;
    localparam int CBT_GCF_LNK_POS = 4;

    // Reset values: 9 Tq nominal bit, 5 Tq data bit, prescaler ratio 1
    localparam logic [31:0] CBT_NOM_RST = 32'h0004_1400;
    localparam logic [31:0] CBT_DAT_RST = 32'h0000_2100;
    localparam logic [31:0] CBT_GCF_RST = 32'h0000_0000;

    localparam logic [1:0] CBT_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CBT_RESP_SLVERR = 2'h2;

    localparam int CBT_MAX_BYTES = 64;

    typedef enum logic [1:0] {
        CBT_P_IDLE = 2'b01,
        CBT_P_BUSY = 2'b10
    } cbt_pri_t;

    typedef struct packed {
        logic [3:0]                   dlc;
        logic [3:0]                   rule_dlc;
        logic [CBT_MAX_BYTES*8-1:0]   data;
    } cbt_rx_t;

    typedef struct packed {
        logic [3:0]                   dlc;
        logic [CBT_MAX_BYTES*8-1:0]   data;
    } cbt_store_t;

    // Payload length in bytes for a DLC code
    function automatic logic [6:0] cbt_dlc_len(input logic [3:0] dlc);
        logic [6:0] len;
        case (dlc)
            4'h9: len = 7'h0C;
            4'hA: len = 7'h10;
            4'hB: len = 7'h14;
            4'hC: len = 7'h18;
            4'hD: len = 7'h20;
            4'hE: len = 7'h30;
            4'hF: len = 7'h40;
            default: len = {3'h0, dlc};
        endcase
        return len;
    endfunction

endpackage

// [hdl/cbt_tq_gen.sv]
/*
 * Time quantum generator: one tick every (field + 1) clocks.
 * Assumes the field is stable except in reset modes; restart re-phases.
 */
`timescale 1ns/100ps
module cbt_tq_gen
    import cbt_pkg::*;
#(
    parameter int W = 10
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] ratio_field,
    input  wire logic         restart,
    output logic              tq_tick
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
        logic [W-1:0] gap;
        logic         clean;
    } cbt_tq_st_t;

    cbt_tq_st_t s_q;
    cbt_tq_st_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        // Quantum = input clock divided by prescaler ratio
        if (restart) begin
            s_d.cnt = '0;
        end else if (s_q.cnt == ratio_field) begin
            s_d.cnt  = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
        s_d.gap   = s_q.tick ? '0 : s_q.gap + 1'b1;
        s_d.clean = ~restart & (s_q.tick | s_q.clean);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tq_tick = s_q.tick;

    tick_spacing_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_q.tick && s_q.clean && $stable(ratio_field) |-> s_q.gap == ratio_field
    ) else $error("tq tick spacing differs from prescaler ratio");

endmodule

// [hdl/cbt_top.sv]
/*
 * CAN global block: bit timing, transmit priority selection, DLC check
 * and replacement, with AXI4-Lite registers. Assumes all inputs are
 * synchronous to aclk and configuration changes only in reset modes.
 */
// Our own choices: the AXI4-Lite slave port and the register offsets.
// Operation
// - Each bit is sync segment, then time segment one, then time segment two.
// - Time quantum is the CAN clock divided by the prescaler ratio.
// - Hard sync on recessive-to-dominant edge during interframe space.
// - Nominal prescaler ratio is 10-bit field plus one.
// - Data prescaler ratio is 8-bit field plus one, same formula.
// - One priority method setting shared by all channels.
// - ID mode: arbitration order over buffers and oldest FIFO entry.
// - ID mode: equal identifiers go lowest-numbered buffer first.
// - Buffer mode: lowest-numbered pending buffer goes first.
// - Buffer mode: linked FIFO takes its linked buffer's number.
// - Priority is re-evaluated after lost arbitration or error.
// - DLC filtering only on accepted frames and only when enabled.
// - Received DLC below rule DLC is discarded as a DLC error.
// - DLC replacement acts only while the DLC check is enabled.
// - Replacement stores rule DLC and zeroes bytes beyond its length.
// - Without replacement every received data byte is stored.
// - Rule DLC of zero stores the frame with its own DLC.
`timescale 1ns/100ps
module cbt_top
    import cbt_pkg::*;
#(
    parameter int NTX = 4,
    parameter int IW  = $clog2(NTX + 1)
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [7:0]            awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [7:0]            araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    input  wire logic                  rx_in,
    input  wire logic                  bus_idle,
    output logic                       sample_pulse,
    output logic                       sample_bit,
    output logic                       bit_start,
    output logic                       hard_sync,
    input  wire logic [NTX-1:0]        tx_req,
    input  wire logic [NTX-1:0][28:0]  tx_id,
    input  wire logic                  fifo_valid,
    input  wire logic [28:0]           fifo_id,
    input  wire logic                  tx_start,
    input  wire logic                  tx_retry,
    input  wire logic                  tx_done,
    output logic                       sel_valid,
    output logic [IW-1:0]              sel_idx,
    output logic [28:0]                sel_id,
    output logic                       fifo_pop,
    input  wire logic                  rx_valid,
    input  wire cbt_rx_t               rx_frame,
    output logic                       st_valid,
    output cbt_store_t                 st_frame,
    output logic                       dlc_err
);

    typedef struct packed {
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [31:0] nom;
        logic [31:0] dat;
        logic [31:0] gcf;
        logic        rx_prev;
        logic [8:0]  cnt;
        logic        sample;
        logic        sbit;
        logic        bstart;
        logic        hsync;
        cbt_pri_t    pri;
        logic        sel_valid;
        logic [IW-1:0] sel_idx;
        logic [28:0] sel_id;
        logic        fifo_pop;
        logic        st_valid;
        cbt_store_t  st;
        logic        dlc_err;
        logic [15:0] err_cnt;
    } cbt_st_t;

    cbt_st_t s_q;
    cbt_st_t s_d;

    // Register index: 0..3 mapped, 4 unmapped
    function automatic logic [2:0] reg_sel(input logic [7:0] a);
        logic [2:0] r;
        r = 3'h4;
        if (a == CBT_NOM_OFS) begin
            r = 3'h0;
        end else if (a == CBT_DAT_OFS) begin
            r = 3'h1;
        end else if (a == CBT_GCF_OFS) begin
            r = 3'h2;
        end else if (a == CBT_STS_OFS) begin
            r = 3'h3;
        end
        return r;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  b);
        logic [31:0] m;
        m = o;
        for (int i = 0; i < 4; i++) begin
            if (b[i]) begin
                m[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // Bit timing selection; data phase uses the data prescaler
    logic        data_ph;
    logic [9:0]  brp;
    logic [8:0]  ts1;
    logic [8:0]  total;
    logic        fall;
    logic        tq_tick;
    logic        cfg_wr;

    always_comb begin
        data_ph = s_q.gcf[CBT_GCF_DPH_POS];
        if (data_ph) begin
            brp   = {2'b00, s_q.dat[CBT_DAT_BRP_POS +: 8]};
            ts1   = {4'h0, s_q.dat[CBT_DAT_TS1_POS +: 5]} + 9'd1;
            total = ts1 + {5'h0, s_q.dat[CBT_DAT_TS2_POS +: 4]} + 9'd2;
        end else begin
            brp   = s_q.nom[CBT_NOM_BRP_POS +: 10];
            ts1   = {1'b0, s_q.nom[CBT_NOM_TS1_POS +: 8]} + 9'd1;
            total = ts1 + {2'b00, s_q.nom[CBT_NOM_TS2_POS +: 7]} + 9'd2;
        end
        fall = s_q.rx_prev & ~rx_in;
        cfg_wr = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
    end

    cbt_tq_gen #(.W (10)) u_tq (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .ratio_field (brp),
        .restart     (fall & bus_idle | cfg_wr),
        .tq_tick     (tq_tick)
    );

    // Transmit priority candidate search, FIFO is candidate NTX
    logic            best_v;
    logic [IW-1:0]   best_i;
    logic [28:0]     best_id;
    logic [28+IW:0]  best_k;
    logic [28+IW:0]  key;
    logic            pend;
    logic [28:0]     cid;
    logic [IW-1:0]   prio;

    always_comb begin
        best_v  = 1'b0;
        best_i  = '0;
        best_id = '0;
        best_k  = '0;
        key     = '0;
        pend    = 1'b0;
        cid     = '0;
        prio    = '0;
        for (int i = 0; i <= NTX; i++) begin
            if (i < NTX) begin
                pend = tx_req[i];
                cid  = tx_id[i];
                prio = IW'(i);
            end else begin
                // Only the oldest FIFO entry is offered
                pend = fifo_valid;
                cid  = fifo_id;
                prio = s_q.gcf[CBT_GCF_LNK_POS +: IW];
            end
            // One global method bit for all channels
            if (s_q.gcf[CBT_GCF_PRI_POS]) begin
                key = {29'h0, prio};
            end else begin
                key = {cid, IW'(i)};
            end
            // Strict compare: earlier buffer wins ties
            if (pend && (!best_v || key < best_k)) begin
                best_v  = 1'b1;
                best_k  = key;
                best_i  = IW'(i);
                best_id = cid;
            end
        end
    end

    logic [6:0] rule_len;

    always_comb begin
        s_d = s_q;
        rule_len = cbt_dlc_len(rx_frame.rule_dlc);

        // AXI4-Lite write channel, address and data in either order
        if (awvalid && s_q.awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = awaddr;
        end
        if (wvalid && s_q.wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = wdata;
            s_d.wstrb = wstrb;
        end
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = CBT_RESP_OKAY;
            case (reg_sel(s_q.awaddr))
                3'h0: s_d.nom = merge(s_q.nom, s_q.wdata, s_q.wstrb);
                3'h1: s_d.dat = merge(s_q.dat, s_q.wdata, s_q.wstrb);
                3'h2: s_d.gcf = merge(s_q.gcf, s_q.wdata, s_q.wstrb);
                3'h3: s_d.bresp = CBT_RESP_OKAY;
                default: s_d.bresp = CBT_RESP_SLVERR;
            endcase
        end
        s_d.awready = ~s_d.aw_got & ~s_d.bvalid;
        s_d.wready  = ~s_d.w_got & ~s_d.bvalid;

        // AXI4-Lite read channel
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = CBT_RESP_OKAY;
            case (reg_sel(araddr))
                3'h0: s_d.rdata = s_q.nom;
                3'h1: s_d.rdata = s_q.dat;
                3'h2: s_d.rdata = s_q.gcf;
                3'h3: s_d.rdata = {s_q.err_cnt, 7'h00, s_q.cnt};
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = CBT_RESP_SLVERR;
                end
            endcase
        end
        s_d.arready = ~s_d.rvalid;

        // Bit position counter in quanta, 0 is the sync segment
        s_d.rx_prev = rx_in;
        s_d.sample  = 1'b0;
        s_d.bstart  = 1'b0;
        s_d.hsync   = 1'b0;
        if (fall && bus_idle) begin
            // Edge marks the sync quantum; restart at segment one
            s_d.cnt   = 9'd1;
            s_d.hsync = 1'b1;
        end else if (cfg_wr) begin
            s_d.cnt = '0; // Re-phase so a shorter bit never overshoots
        end else if (tq_tick) begin
            if (s_q.cnt == total - 9'd1) begin
                s_d.cnt    = '0;
                s_d.bstart = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 9'd1;
            end
            // Sample after sync plus segment one quanta
            if (s_q.cnt == ts1) begin
                s_d.sample = 1'b1;
                s_d.sbit   = rx_in;
            end
        end

        // Priority engine; selection frozen while a frame is on the bus
        s_d.fifo_pop = 1'b0;
        case (s_q.pri)
            CBT_P_IDLE: begin
                s_d.sel_valid = best_v;
                s_d.sel_idx   = best_i;
                s_d.sel_id    = best_id;
                if (tx_start && s_q.sel_valid) begin
                    s_d.pri       = CBT_P_BUSY;
                    s_d.sel_valid = s_q.sel_valid;
                    s_d.sel_idx   = s_q.sel_idx;
                    s_d.sel_id    = s_q.sel_id;
                    // Next FIFO entry competes once sending begins
                    s_d.fifo_pop  = (s_q.sel_idx == IW'(NTX));
                end
            end
            CBT_P_BUSY: begin
                if (tx_retry || tx_done) begin
                    // Fresh search before any resend
                    s_d.pri       = CBT_P_IDLE;
                    s_d.sel_valid = 1'b0;
                end
            end
            default: s_d.pri = CBT_P_IDLE;
        endcase

        // DLC check and replacement on accepted frames
        s_d.st_valid = 1'b0;
        s_d.dlc_err  = 1'b0;
        if (rx_valid) begin
            if (!s_q.gcf[CBT_GCF_DCE_POS] || rx_frame.rule_dlc == 4'h0) begin
                // No filtering, own DLC, all bytes
                s_d.st_valid = 1'b1;
                s_d.st.dlc   = rx_frame.dlc;
                s_d.st.data  = rx_frame.data;
            end else if (rx_frame.dlc < rx_frame.rule_dlc) begin
                s_d.dlc_err = 1'b1;
                s_d.err_cnt = s_q.err_cnt + 16'h0001;
            end else if (s_q.gcf[CBT_GCF_DRE_POS]) begin
                s_d.st_valid = 1'b1;
                s_d.st.dlc   = rx_frame.rule_dlc;
                for (int b = 0; b < CBT_MAX_BYTES; b++) begin
                    s_d.st.data[b*8 +: 8] = (7'(b) < rule_len) ?
                        rx_frame.data[b*8 +: 8] : 8'h00;
                end
            end else begin
                s_d.st_valid = 1'b1;
                s_d.st.dlc   = rx_frame.dlc;
                s_d.st.data  = rx_frame.data;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q      <= '0;
            s_q.nom  <= CBT_NOM_RST;
            s_q.dat  <= CBT_DAT_RST;
            s_q.gcf  <= CBT_GCF_RST;
            s_q.pri  <= CBT_P_IDLE;
            s_q.rx_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign awready      = s_q.awready;
    assign wready       = s_q.wready;
    assign bvalid       = s_q.bvalid;
    assign bresp        = s_q.bresp;
    assign arready      = s_q.arready;
    assign rvalid       = s_q.rvalid;
    assign rdata        = s_q.rdata;
    assign rresp        = s_q.rresp;
    assign sample_pulse = s_q.sample;
    assign sample_bit   = s_q.sbit;
    assign bit_start    = s_q.bstart;
    assign hard_sync    = s_q.hsync;
    assign sel_valid    = s_q.sel_valid;
    assign sel_idx      = s_q.sel_idx;
    assign sel_id       = s_q.sel_id;
    assign fifo_pop     = s_q.fifo_pop;
    assign st_valid     = s_q.st_valid;
    assign st_frame     = s_q.st;
    assign dlc_err      = s_q.dlc_err;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    hard_sync_a: assert property (
        fall && bus_idle |=> s_q.hsync && s_q.cnt == 9'd1
    ) else $error("hard sync did not restart the bit");
    sample_point_a: assert property (
        s_q.sample |-> $past(s_q.cnt) == $past(ts1) && $past(tq_tick)
    ) else $error("sample taken away from segment one end");
    bit_wrap_a: assert property (
        s_q.bstart |-> $past(s_q.cnt) == $past(total) - 9'd1
    ) else $error("bit ended at wrong quantum");
    id_order_a: assert property (
        s_q.pri == CBT_P_IDLE && !s_q.gcf[CBT_GCF_PRI_POS] && tx_req[0]
        && !tx_start |=> s_q.sel_valid
        && s_q.sel_id <= $past(tx_id[0])
    ) else $error("selected identifier loses arbitration");
    num_order_a: assert property (
        s_q.pri == CBT_P_IDLE && s_q.gcf[CBT_GCF_PRI_POS] && tx_req[0]
        && !tx_start ##1 s_q.gcf[CBT_GCF_PRI_POS] |-> s_q.sel_idx == '0
        || s_q.gcf[CBT_GCF_LNK_POS +: IW] == '0
    ) else $error("lowest pending buffer not chosen");
    retry_eval_a: assert property (
        s_q.pri == CBT_P_BUSY && tx_retry |=> s_q.pri == CBT_P_IDLE
        ##1 s_q.sel_valid == $past(best_v)
    ) else $error("no fresh search after retry");
    dlc_error_a: assert property (
        rx_valid && s_q.gcf[CBT_GCF_DCE_POS] && rx_frame.rule_dlc != 4'h0
        && rx_frame.dlc < rx_frame.rule_dlc |=> s_q.dlc_err && !s_q.st_valid
    ) else $error("short frame was stored");
    dlc_replace_a: assert property (
        rx_valid && s_q.gcf[CBT_GCF_DCE_POS] && s_q.gcf[CBT_GCF_DRE_POS]
        && rx_frame.rule_dlc != 4'h0 && rx_frame.dlc >= rx_frame.rule_dlc
        |=> s_q.st_valid && s_q.st.dlc == $past(rx_frame.rule_dlc)
    ) else $error("rule DLC not stored");
    dlc_bypass_a: assert property (
        rx_valid && !s_q.gcf[CBT_GCF_DCE_POS] |=> s_q.st_valid
        && s_q.st == {$past(rx_frame.dlc), $past(rx_frame.data)}
    ) else $error("frame altered with check disabled");
    bresp_hold_a: assert property (
        s_q.bvalid && !bready |=> s_q.bvalid
    ) else $error("write response dropped early");

    cover_hsync_c:  cover property (s_q.hsync ##[1:50] s_q.sample);
    cover_fifo_c:   cover property (s_q.fifo_pop);
    cover_dlcerr_c: cover property (s_q.dlc_err);
    cover_retry_c:  cover property (s_q.pri == CBT_P_BUSY && tx_retry);

endmodule

// [test/cbt_can_node.sv]
/*
 * Model bus node: recessive idle line, one dominant frame start per sof.
 * Assumes sof is a one-cycle pulse from the bench on aclk.
 */
`timescale 1ns/100ps
module cbt_can_node (
    input  wire logic aclk,
    input  wire logic sof,
    output logic      rx_in,
    output logic      bus_idle
);
    logic [3:0] cnt_q = 4'h0;
    always_ff @(posedge aclk) begin
        cnt_q <= sof ? 4'h8 : cnt_q - 4'(cnt_q != 4'h0);
    end
    // Line falls only while idle, the one edge a hard sync may use
    assign rx_in    = cnt_q == 4'h0;
    assign bus_idle = cnt_q == 4'h0 || cnt_q == 4'h8;
endmodule

// [test/can_bit_timing_priority_dlc_test.sv]
/*
 * Bench: registers, bit timing, transmit priority and DLC filter, each
 * against a model. Assumes cbt_top with four buffers and a model node.
 */
`timescale 1ns/100ps
module can_bit_timing_priority_dlc_test;
    import cbt_pkg::*;
    logic aclk = '0, aresetn = '0, sof = '0, awvalid = '0, wvalid = '0;
    logic bready = '0, arvalid = '0, rready = '0, tx_start = '0;
    logic tx_retry = '0, tx_done = '0, fifo_valid = '0, rx_valid = '0;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = 4'hF, tx_req = '0;
    logic [3:0][28:0] tx_id = '0;
    logic [28:0] fifo_id = '0, sel_id;
    cbt_rx_t     rx_frame = '0;
    cbt_store_t  st_frame;
    logic awready, wready, bvalid, arready, rvalid, rx_in, bus_idle;
    logic sample_pulse, sample_bit, bit_start, hard_sync, sel_valid;
    logic fifo_pop, st_valid, dlc_err;
    logic [1:0] bresp, rresp;
    logic [2:0] sel_idx;
    wire  [2:0] ev = {hard_sync, bit_start, sample_pulse};
    int errors = 0, check_count = 0;
    int lens[16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 12, 16, 20, 24, 32, 48, 64};
    always #50 aclk = ~aclk;
    cbt_top i_cbt_top (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rx_in,
        .bus_idle, .sample_pulse, .sample_bit, .bit_start, .hard_sync,
        .tx_req, .tx_id, .fifo_valid, .fifo_id, .tx_start, .tx_retry,
        .tx_done, .sel_valid, .sel_idx, .sel_id, .fifo_pop, .rx_valid,
        .rx_frame, .st_valid, .st_frame, .dlc_err);
    cbt_can_node i_cbt_can_node (.aclk, .sof, .rx_in, .bus_idle);
    task automatic conclude();
        $display("errors %0d check_count %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    // Sampled at the falling edge, so no race with the design's flops
    task automatic wt(input int s, output int c);
        c = 0;
        do begin
            @(negedge aclk);
            c++;
        end while (ev[s] !== 1'b1 && c < 999);
        if (c == 999) begin
            chk('0, "wait ran out");
            conclude();
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] x = CBT_RESP_OKAY);
        logic ah, wh, bh;
        logic [1:0] r;
        bh = '0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= '1;
        wvalid <= '1;
        bready <= '1;
        for (int n = 0; n < 40 && !bh; n++) begin
            @(negedge aclk);
            ah = awready === '1;
            wh = wready === '1;
            bh = bvalid === '1;
            r = bresp;
            @(posedge aclk);
            if (ah) awvalid <= '0;
            if (wh) wvalid <= '0;
        end
        bready <= '0;
        chk(bh && r === x, "write response");
        if (!bh) conclude();
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x,
                         input logic [1:0] xr);
        logic ah, rh;
        logic [31:0] d;
        logic [1:0] r;
        rh = '0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= '1;
        rready <= '1;
        for (int n = 0; n < 40 && !rh; n++) begin
            @(negedge aclk);
            ah = arready === '1;
            rh = rvalid === '1;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ah) arvalid <= '0;
        end
        rready <= '0;
        chk(rh && d === x && r === xr, "read");
        if (!rh) conclude();
    endtask
    initial begin
        int br, s1, s2, p1, p2, c1, c2, best, key, bk, lk, it;
        logic pm, fv, pass, rep;
        logic [3:0] rq;
        logic [3:0][28:0] ids;
        logic [28:0] fid, bid, sid;
        logic [2:0] g;
        cbt_rx_t f;
        cbt_store_t e;
        void'($urandom(20774));
        repeat (2) @(posedge aclk);
        aresetn <= '1;
        rdchk(CBT_NOM_OFS, CBT_NOM_RST, CBT_RESP_OKAY);
        rdchk(CBT_DAT_OFS, CBT_DAT_RST, CBT_RESP_OKAY);
        rdchk(CBT_GCF_OFS, CBT_GCF_RST, CBT_RESP_OKAY);
        rdchk(8'h40, '0, CBT_RESP_SLVERR);
        axw(8'h40, '0, CBT_RESP_SLVERR);
        for (int k = 0; k < 2; k++) begin
            br = 3 - k;
            s1 = 5 - 2 * k;
            s2 = 3 - k;
            p1 = k ? CBT_DAT_TS1_POS : CBT_NOM_TS1_POS;
            p2 = k ? CBT_DAT_TS2_POS : CBT_NOM_TS2_POS;
            axw(k ? CBT_DAT_OFS : CBT_NOM_OFS,
                32'(br - 1 | s1 - 1 << p1 | s2 - 1 << p2));
            axw(CBT_GCF_OFS, 32'(k << CBT_GCF_DPH_POS));
            wt(1, c1);
            wt(0, c1);
            chk(sample_bit === '1, "sample bit");
            wt(1, c2);
            chk(c2 == br * s2, "sample point");
            chk(c1 + c2 == br * (1 + s1 + s2), "bit time");
        end
        @(posedge aclk);
        sof <= '1;
        @(posedge aclk);
        sof <= '0;
        wt(2, c1);
        chk(c1 == 2, "hard sync");
        for (it = 0; it < 40; it++) begin
            pm = it[0];
            lk = $urandom_range(3);
            axw(CBT_GCF_OFS, 32'(pm | lk << CBT_GCF_LNK_POS));
            rq = 4'($urandom());
            fv = 1'($urandom());
            // Small identifiers so that ties come up often
            fid = 29'($urandom_range(3));
            for (int i = 0; i < 4; i++) ids[i] = 29'($urandom_range(3));
            bk = 999;
            for (int i = 0; i < 5; i++) begin
                bid = i < 4 ? ids[i] : fid;
                key = pm ? 2 * (i < 4 ? i : lk) + i / 4 : 8 * int'(bid) + i;
                if ((i < 4 ? rq[i] : fv) && key < bk) begin
                    bk = key;
                    best = i;
                    sid = bid;
                end
            end
            tx_req <= rq;
            tx_id <= ids;
            fifo_valid <= fv;
            fifo_id <= fid;
            repeat (2) @(posedge aclk);
            @(negedge aclk);
            chk(sel_valid === (bk < 999), "pending");
            if (bk < 999) chk(sel_idx === 3'(best) && sel_id === sid, "pick");
            @(posedge aclk);
            tx_start <= bk < 999;
            @(posedge aclk);
            tx_start <= '0;
            @(negedge aclk);
            chk(fifo_pop === (best == 4 && bk < 999), "advance");
            @(posedge aclk);
            tx_retry <= it[1] && bk < 999;
            tx_done <= !it[1] && bk < 999;
            @(posedge aclk);
            tx_retry <= '0;
            tx_done <= '0;
        end
        for (it = 0; it < 48; it++) begin
            g = 3'($urandom());
            axw(CBT_GCF_OFS, 32'(g & 3'h6));
            f.dlc = 4'($urandom());
            f.rule_dlc = it < 6 ? '0 : 4'($urandom());
            for (int b = 0; b < 16; b++) f.data[b * 32 +: 32] = $urandom();
            pass = !g[1] || f.rule_dlc == 0 || f.dlc >= f.rule_dlc;
            rep = g[1] && g[2] && f.rule_dlc != 0;
            e.dlc = rep ? f.rule_dlc : f.dlc;
            e.data = f.data;
            for (int b = 0; b < 64; b++)
                if (rep && b >= lens[f.rule_dlc]) e.data[b * 8 +: 8] = '0;
            rx_frame <= f;
            rx_valid <= '1;
            @(posedge aclk);
            rx_valid <= '0;
            @(negedge aclk);
            chk(st_valid === pass && dlc_err === !pass, "filter");
            if (pass) chk(st_frame === e, "stored");
        end
        conclude();
    end
endmodule
